/* bdcu_fifo.sv */
// Word FIFO with a registered output stage
module bdcu_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32
) (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic in_valid_in,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic in_ready_out,
    output logic out_valid_out,
    output logic [WIDTH-1:0] out_data_out,
    input wire logic out_ready_in
);
    // DEPTH must be a power of two so the pointers wrap cleanly
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0] wp_ff;
    logic [AW-1:0] rp_ff;
    logic [AW:0] cnt_ff;
    logic [WIDTH-1:0] out_ff;
    logic out_v_ff;

    wire logic push = in_valid_in && in_ready_out;
    wire logic pull = (cnt_ff != '0) && (!out_v_ff || out_ready_in);

    assign in_ready_out = (cnt_ff != (AW+1)'(DEPTH));
    assign out_valid_out = out_v_ff;
    assign out_data_out = out_ff;

    always_ff @(posedge clk_in) begin
        if (push) begin
            mem_ff[wp_ff] <= in_data_in;
        end
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            wp_ff <= '0;
            rp_ff <= '0;
            cnt_ff <= '0;
            out_ff <= '0;
            out_v_ff <= 1'b0;
        end else begin
            if (push) wp_ff <= wp_ff + 1'b1;
            if (pull) rp_ff <= rp_ff + 1'b1;
            cnt_ff <= cnt_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pull};
            if (pull) begin
                out_ff <= mem_ff[rp_ff];
                out_v_ff <= 1'b1;
            end else if (out_ready_in) begin
                out_v_ff <= 1'b0;
            end
        end
    end
endmodule

/* bdcu_host.sv */
// Development system model: master of the serial debug link
module bdcu_host (
    output logic dsclk_out,
    output logic dsi_out,
    input wire logic dso_in
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        dsclk_out = 1'h1;
        dsi_out = 1'h0;
    end
    // One word, MSB first, clock idles high between words
    // Called on a falling clock edge; whole periods keep pins off the rising edge
    task automatic xfer(input logic [16:0] tx, output logic [16:0] rx);
        for (int i = 16; i >= 0; i--) begin
            dsclk_out = 1'h0;
            dsi_out = tx[i];
            #80;
            rx[i] = dso_in;
            dsclk_out = 1'h1;
            #80;
        end
        // Released line must not look stale
        dsi_out = ~tx[0];
        #320;
    endtask
endmodule

/* bdcu_pkg.sv */
// Shared constants, types and decode helpers of the debug command unit
package bdcu_pkg;
    localparam int LAST_BIT = 16;
    localparam int OP_HI = 15;
    localparam int OP_LO = 10;
    localparam int RW_BIT = 8;
    localparam int SZ_HI = 7;
    localparam int SZ_LO = 6;
    localparam int AD_BIT = 3;
    localparam int RST_CYCLES = 512;
    localparam int FIFO_DEPTH = 32;
    localparam int DATA_W = 16;

    // Link messages: status/control bit, then 16 data bits
    localparam logic [16:0] MSG_COMPLETE = 17'h0FFFF;
    localparam logic [16:0] MSG_NOT_READY = 17'h10000;
    localparam logic [16:0] MSG_BERR = 17'h10001;
    localparam logic [16:0] MSG_ILLEGAL = 17'h1FFFF;

    localparam logic [5:0] OP_NOP = 6'h00;
    localparam logic [5:0] OP_RST = 6'h01;
    localparam logic [5:0] OP_CALL = 6'h02;
    localparam logic [5:0] OP_GO = 6'h03;
    localparam logic [5:0] OP_MEM = 6'h06;
    localparam logic [5:0] OP_BLK = 6'h07;
    localparam logic [5:0] OP_CORE_REG = 6'h08;
    localparam logic [5:0] OP_CTL_REG = 6'h09;

    localparam logic [1:0] SZ_BYTE = 2'h0;
    localparam logic [1:0] SZ_WORD = 2'h1;
    localparam logic [1:0] SZ_LONG = 2'h2;
    localparam logic [1:0] SZ_RSVD = 2'h3;

    localparam logic [2:0] NO_WORDS = 3'h0;
    localparam logic [2:0] ONE_WORD = 3'h1;
    localparam logic [2:0] TWO_WORDS = 3'h2;
    localparam logic [7:0] BYTE_PAD = 8'h00;
    localparam logic [31:0] INC_BYTE = 32'h1;
    localparam logic [31:0] INC_WORD = 32'h2;
    localparam logic [31:0] INC_LONG = 32'h4;

    typedef logic [16:0] bdcu_word_t;

    typedef enum logic [3:0] {
        K_NOP, K_RST, K_CALL, K_GO, K_READ, K_WRITE, K_DUMP,
        K_FILL, K_RREG, K_WREG, K_RCTL, K_WCTL, K_ILL
    } bdcu_kind_e;

    typedef struct packed {
        logic we;
        logic ctl;
        logic [3:0] sel;
        logic [31:0] wdata;
    } bdcu_reg_req_s;

    typedef struct packed {
        logic we;
        logic [2:0] fc;
        logic [1:0] size;
        logic [31:0] addr;
        logic [31:0] wdata;
    } bdcu_mem_req_s;

    function automatic bdcu_kind_e cmd_kind(input logic [15:0] w);
        logic [5:0] op;
        logic rd;
        logic bad;
        op = w[OP_HI:OP_LO];
        rd = w[RW_BIT];
        bad = (w[SZ_HI:SZ_LO] == SZ_RSVD);
        if (op == OP_NOP) return K_NOP;
        else if (op == OP_RST) return K_RST;
        else if (op == OP_CALL) return K_CALL;
        else if (op == OP_GO) return K_GO;
        else if (op == OP_MEM) return bad ? K_ILL : (rd ? K_READ : K_WRITE);
        else if (op == OP_BLK) return bad ? K_ILL : (rd ? K_DUMP : K_FILL);
        else if (op == OP_CORE_REG) return rd ? K_RREG : K_WREG;
        else if (op == OP_CTL_REG) return rd ? K_RCTL : K_WCTL;
        return K_ILL;
    endfunction

    function automatic logic [2:0] ext_words(input bdcu_kind_e k, input logic [1:0] sz);
        logic [2:0] d;
        d = (sz == SZ_LONG) ? TWO_WORDS : ONE_WORD;
        if (k == K_WREG || k == K_WCTL) return TWO_WORDS;
        else if (k == K_READ) return TWO_WORDS;
        else if (k == K_WRITE) return TWO_WORDS + d;
        else if (k == K_FILL) return d;
        return NO_WORDS;
    endfunction

    function automatic logic [31:0] size_bytes(input logic [1:0] sz);
        if (sz == SZ_LONG) return INC_LONG;
        else if (sz == SZ_WORD) return INC_WORD;
        return INC_BYTE;
    endfunction
endpackage

/* bdcu_top.sv */
// Background debug command unit: serial link, command decode and sequencer
// Function
// - Decode the six-bit operation field; up to 64 commands.
// - Direction bit set sends data to host; clear writes data inward.
// - Size field 00 byte, 01 word, 10 long, 11 reserved.
// - Address/data bit picks address register when one, data when zero.
// - Addresses take two extension words; immediates one or two by size.
// - Multi-word values travel most significant word first.
// - While a command arrives, shift out previous low result or complete.
// - Transfer after a command returns not-ready, or illegal if unknown.
// - Not-ready only matters during bus cycles; accept within eight clocks.
// - Memory read starts as soon as the low address word arrives.
// - Transfers during a debug memory access receive not-ready.
// - Long and register read results fill the next two transfers; host sends next opcode last.
// - Bus or address error returns the error status, not data.
// - Peripheral reset drives the reset output for 512 cycles.
// - Resume flushes the pipeline and continues at the return PC.
// - Call stacks the PC and starts user patch code.
// - No-op changes nothing and serves as filler.
// - Reads use the source space code, writes the destination one.
// - Register read returns the full long word, upper half first.
// - Register write replaces the whole selected register.
// - Link words are 17 bits, status bit first; host bit ignored.
// - Messages: complete, not-ready, bus error and illegal encodings.
// - Dump and fill reuse the block address and advance it by size.
module bdcu_top #(
    parameter int FIFO_DEPTH_P = bdcu_pkg::FIFO_DEPTH,
    parameter int RST_CYCLES_P = bdcu_pkg::RST_CYCLES
) (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic dsclk_in,
    input wire logic dsi_in,
    output logic dso_out,
    output logic link_ready_out,
    input wire logic [2:0] source_space_code_in,
    input wire logic [2:0] destination_space_code_in,
    output logic reg_req_out,
    output bdcu_pkg::bdcu_reg_req_s reg_req_data_out,
    input wire logic [31:0] reg_rdata_in,
    input wire logic reg_ack_in,
    output logic mem_req_out,
    output bdcu_pkg::bdcu_mem_req_s mem_req_data_out,
    input wire logic [31:0] mem_rdata_in,
    input wire logic mem_done_in,
    input wire logic mem_err_in,
    output logic resume_out,
    output logic call_out,
    output logic periph_rst_out
);
    import bdcu_pkg::*;

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (sys_rst_in);

    typedef enum {S_CMD, S_EXT, S_EXEC, S_REG, S_MEM, S_RESP} bdcu_state_e;

    localparam logic [4:0] LAST_IDX = 5'(LAST_BIT);
    localparam int RST_W = $clog2(RST_CYCLES_P + 1);
    localparam logic [RST_W-1:0] RST_LOAD = RST_W'(RST_CYCLES_P);

    ////////////////////////////////////////////////////////////////////////
    // Link pin synchronisers and edge detect

    logic sclk_s1_ff;
    logic sclk_s2_ff;
    logic sclk_s3_ff;
    logic dsi_s1_ff;
    logic dsi_s2_ff;

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            sclk_s1_ff <= 1'b1;
            sclk_s2_ff <= 1'b1;
            sclk_s3_ff <= 1'b1;
            dsi_s1_ff <= 1'b0;
            dsi_s2_ff <= 1'b0;
        end else begin
            sclk_s1_ff <= dsclk_in;
            sclk_s2_ff <= sclk_s1_ff;
            sclk_s3_ff <= sclk_s2_ff;
            dsi_s1_ff <= dsi_in;
            dsi_s2_ff <= dsi_s1_ff;
        end
    end

    wire logic rise = sclk_s2_ff && !sclk_s3_ff;

    ////////////////////////////////////////////////////////////////////////
    // 17-bit shifters

    logic [4:0] bit_ff;
    logic [16:0] rx_ff;
    logic done_ff;
    bdcu_word_t tx_ff;
    logic two_ff;

    bdcu_state_e state_ff;
    bdcu_word_t rsp0_ff;
    bdcu_word_t rsp1_ff;
    logic rsp_two_ff;

    // Clock parked high with no bit pending, so a reload cannot tear a word
    wire logic link_idle = (bit_ff == '0) && sclk_s2_ff && sclk_s3_ff && !done_ff;
    wire logic seq_load = (state_ff == S_RESP) && link_idle;

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            bit_ff <= '0;
            rx_ff <= '0;
            done_ff <= 1'b0;
        end else begin
            done_ff <= rise && (bit_ff == LAST_IDX);
            if (rise) begin
                rx_ff <= {rx_ff[LAST_BIT-1:0], dsi_s2_ff};
                bit_ff <= (bit_ff == LAST_IDX) ? '0 : bit_ff + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            tx_ff <= MSG_COMPLETE;
            two_ff <= 1'b0;
        end else if (rise) begin
            tx_ff <= {tx_ff[LAST_BIT-1:0], 1'b0};
        end else if (done_ff) begin
            tx_ff <= two_ff ? rsp1_ff : MSG_NOT_READY;
            two_ff <= 1'b0;
        end else if (seq_load) begin
            tx_ff <= rsp0_ff;
            two_ff <= rsp_two_ff;
        end
    end

    assign dso_out = tx_ff[LAST_BIT];

    ////////////////////////////////////////////////////////////////////////
    // Received word queue

    logic fifo_out_valid;
    logic [DATA_W-1:0] word_w;
    wire logic fifo_out_ready = (state_ff == S_CMD) || (state_ff == S_EXT);
    // Host data bit 16 is ignored; words sent with the upper result word or while busy are dropped
    wire logic fifo_in_valid = done_ff && !two_ff && fifo_out_ready;
    wire logic pop = fifo_out_valid && fifo_out_ready;

    bdcu_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(FIFO_DEPTH_P)
    ) u_rx_fifo (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .in_valid_in(fifo_in_valid),
        .in_data_in(rx_ff[DATA_W-1:0]),
        .in_ready_out(link_ready_out),
        .out_valid_out(fifo_out_valid),
        .out_data_out(word_w),
        .out_ready_in(fifo_out_ready)
    );

    ////////////////////////////////////////////////////////////////////////
    // Decode

    logic [15:0] cmd_ff;
    bdcu_kind_e kind_ff;
    logic [2:0] left_ff;
    logic [2:0] idx_ff;
    logic [31:0] addr_ff;
    logic [31:0] data_ff;
    logic [31:0] blk_ff;
    logic reg_req_ff;
    bdcu_reg_req_s reg_dat_ff;
    logic mem_req_ff;
    bdcu_mem_req_s mem_dat_ff;
    logic resume_ff;
    logic call_ff;
    logic [RST_W-1:0] rst_cnt_ff;

    wire bdcu_kind_e new_kind = cmd_kind(word_w);
    wire logic [2:0] new_left = ext_words(new_kind, word_w[SZ_HI:SZ_LO]);
    wire logic [1:0] sz = cmd_ff[SZ_HI:SZ_LO];
    wire logic has_addr = (kind_ff == K_READ) || (kind_ff == K_WRITE);
    wire logic to_addr = has_addr && (idx_ff < TWO_WORDS);
    wire logic blk_op = (kind_ff == K_DUMP) || (kind_ff == K_FILL);
    wire logic wr_op = (kind_ff == K_WRITE) || (kind_ff == K_FILL);
    wire logic rd_reg = (kind_ff == K_RREG) || (kind_ff == K_RCTL);
    wire logic ctl_reg = (kind_ff == K_RCTL) || (kind_ff == K_WCTL);
    wire logic [31:0] mem_addr = blk_op ? blk_ff : addr_ff;
    wire logic [2:0] fc = wr_op ? destination_space_code_in : source_space_code_in;
    wire logic [15:0] rd_short = (mem_dat_ff.size == SZ_BYTE) ?
        {BYTE_PAD, mem_rdata_in[7:0]} : mem_rdata_in[15:0];

    ////////////////////////////////////////////////////////////////////////
    // Sequencer

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            state_ff <= S_CMD;
            cmd_ff <= '0;
            kind_ff <= K_NOP;
            left_ff <= '0;
            idx_ff <= '0;
            addr_ff <= '0;
            data_ff <= '0;
            blk_ff <= '0;
            rsp0_ff <= MSG_COMPLETE;
            rsp1_ff <= MSG_COMPLETE;
            rsp_two_ff <= 1'b0;
            reg_req_ff <= 1'b0;
            reg_dat_ff <= '0;
            mem_req_ff <= 1'b0;
            mem_dat_ff <= '0;
            resume_ff <= 1'b0;
            call_ff <= 1'b0;
        end else begin
            resume_ff <= 1'b0;
            call_ff <= 1'b0;
            case (state_ff)
                S_CMD: begin
                    if (pop) begin
                        cmd_ff <= word_w;
                        kind_ff <= new_kind;
                        left_ff <= new_left;
                        idx_ff <= '0;
                        if (new_kind == K_ILL) begin
                            rsp0_ff <= MSG_ILLEGAL;
                            rsp_two_ff <= 1'b0;
                            state_ff <= S_RESP;
                        end else if (new_left == NO_WORDS) begin
                            state_ff <= S_EXEC;
                        end else begin
                            state_ff <= S_EXT;
                        end
                    end
                end
                S_EXT: begin
                    if (pop) begin
                        if (to_addr) begin
                            addr_ff <= {addr_ff[15:0], word_w};
                        end else begin
                            data_ff <= {data_ff[15:0], word_w};
                        end
                        idx_ff <= idx_ff + 1'b1;
                        left_ff <= left_ff - 1'b1;
                        if (left_ff == ONE_WORD) state_ff <= S_EXEC;
                    end
                end
                S_EXEC: begin
                    rsp0_ff <= MSG_COMPLETE;
                    rsp_two_ff <= 1'b0;
                    state_ff <= S_RESP;
                    case (kind_ff)
                        K_RREG, K_WREG, K_RCTL, K_WCTL: begin
                            reg_req_ff <= 1'b1;
                            // Address/data bit and number form one select
                            reg_dat_ff <= '{we: !rd_reg, ctl: ctl_reg,
                                sel: cmd_ff[AD_BIT:0], wdata: data_ff};
                            state_ff <= S_REG;
                        end
                        K_READ, K_WRITE, K_DUMP, K_FILL: begin
                            mem_req_ff <= 1'b1;
                            mem_dat_ff <= '{we: wr_op, fc: fc, size: sz,
                                addr: mem_addr, wdata: data_ff};
                            state_ff <= S_MEM;
                        end
                        K_GO: resume_ff <= 1'b1;
                        K_CALL: call_ff <= 1'b1;
                        default: ;
                    endcase
                end
                S_REG: begin
                    if (reg_ack_in) begin
                        reg_req_ff <= 1'b0;
                        if (!reg_dat_ff.we) begin
                            rsp0_ff <= {1'b0, reg_rdata_in[31:16]};
                            rsp1_ff <= {1'b0, reg_rdata_in[15:0]};
                            rsp_two_ff <= 1'b1;
                        end
                        state_ff <= S_RESP;
                    end
                end
                S_MEM: begin
                    if (mem_done_in) begin
                        mem_req_ff <= 1'b0;
                        blk_ff <= mem_dat_ff.addr + size_bytes(mem_dat_ff.size);
                        if (mem_err_in) begin
                            rsp0_ff <= MSG_BERR;
                        end else if (!mem_dat_ff.we && mem_dat_ff.size == SZ_LONG) begin
                            rsp0_ff <= {1'b0, mem_rdata_in[31:16]};
                            rsp1_ff <= {1'b0, mem_rdata_in[15:0]};
                            rsp_two_ff <= 1'b1;
                        end else if (!mem_dat_ff.we) begin
                            rsp0_ff <= {1'b0, rd_short};
                        end
                        state_ff <= S_RESP;
                    end
                end
                S_RESP: begin
                    if (seq_load) state_ff <= S_CMD;
                end
                default: state_ff <= S_CMD;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Peripheral reset timer; the core itself is left running

    wire logic rst_start = (state_ff == S_EXEC) && (kind_ff == K_RST);

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            rst_cnt_ff <= '0;
        end else if (rst_start) begin
            rst_cnt_ff <= RST_LOAD;
        end else if (rst_cnt_ff != '0) begin
            rst_cnt_ff <= rst_cnt_ff - 1'b1;
        end
    end

    assign periph_rst_out = (rst_cnt_ff != '0);
    assign reg_req_out = reg_req_ff;
    assign reg_req_data_out = reg_dat_ff;
    assign mem_req_out = mem_req_ff;
    assign mem_req_data_out = mem_dat_ff;
    assign resume_out = resume_ff;
    assign call_out = call_ff;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    property p_nr_after_word;
        done_ff && !two_ff |=> tx_ff == MSG_NOT_READY;
    endproperty
    a_nr_after_word: assert property (p_nr_after_word) else $error("no not-ready");

    property p_busy_nr;
        done_ff && state_ff == S_MEM && !mem_done_in |=> tx_ff == MSG_NOT_READY && state_ff == S_MEM;
    endproperty
    a_busy_nr: assert property (p_busy_nr) else $error("busy word answered");

    property p_low_result;
        done_ff && two_ff |=> tx_ff == rsp1_ff && !two_ff;
    endproperty
    a_low_result: assert property (p_low_result) else $error("low word lost");

    property p_load;
        seq_load |=> tx_ff == $past(rsp0_ff) && state_ff == S_CMD;
    endproperty
    a_load: assert property (p_load) else $error("response not loaded");

    property p_rsvd;
        pop && state_ff == S_CMD && word_w[OP_HI:OP_LO] == OP_MEM &&
            word_w[SZ_HI:SZ_LO] == SZ_RSVD |=> state_ff == S_RESP && rsp0_ff == MSG_ILLEGAL;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved size accepted");

    property p_berr;
        state_ff == S_MEM && mem_done_in && mem_err_in |=> rsp0_ff == MSG_BERR && !rsp_two_ff;
    endproperty
    a_berr: assert property (p_berr) else $error("error status missing");

    property p_blk;
        state_ff == S_MEM && mem_done_in && mem_dat_ff.size == SZ_LONG
            |=> blk_ff == $past(mem_dat_ff.addr) + INC_LONG;
    endproperty
    a_blk: assert property (p_blk) else $error("block address step");

    property p_fc;
        $rose(mem_req_out) |-> mem_req_data_out.fc == (mem_req_data_out.we ?
            $past(destination_space_code_in) : $past(source_space_code_in));
    endproperty
    a_fc: assert property (p_fc) else $error("wrong space code");

    property p_rdreg;
        state_ff == S_REG && reg_ack_in && !reg_dat_ff.we |=> rsp_two_ff &&
            rsp0_ff[15:0] == $past(reg_rdata_in[31:16]) && rsp1_ff[15:0] == $past(reg_rdata_in[15:0]);
    endproperty
    a_rdreg: assert property (p_rdreg) else $error("register read order");

    property p_prst;
        $rose(periph_rst_out) |-> ##[511:511] (periph_rst_out ##1 !periph_rst_out);
    endproperty
    a_prst: assert property (p_prst) else $error("reset width");

    property p_rd_start;
        state_ff == S_EXT && pop && left_ff == ONE_WORD && kind_ff == K_READ |-> ##2 mem_req_out;
    endproperty
    a_rd_start: assert property (p_rd_start) else $error("read start late");

    c_two_word: cover property (seq_load && rsp_two_ff);
    c_illegal: cover property (state_ff == S_CMD && pop && new_kind == K_ILL);
    c_berr: cover property (state_ff == S_MEM && mem_done_in && mem_err_in);
    c_prst: cover property ($rose(periph_rst_out));
endmodule

/* tb_background_debug_command_unit.sv */
// Bench: host model drives the link, bus ports answered here
module tb_background_debug_command_unit;
    timeunit 1ns;
    timeprecision 1ns;
    import bdcu_pkg::*;
    logic clk_in = 1'h0;
    logic sys_rst_in = 1'h1;
    logic reg_ack = 1'h0;
    logic mem_done = 1'h0;
    logic mem_err = 1'h0;
    logic mem_hold = 1'h0;
    logic [31:0] rdata = 32'h0;
    logic dsclk, dsi, dso, rdy, reg_req, mem_req, go_p, call_p, prst;
    logic [16:0] r;
    bdcu_reg_req_s reg_d, reg_seen;
    bdcu_mem_req_s mem_d, mem_seen;
    int n_mismatch = 0;
    int compares = 0;
    int n_rst = 0;
    int n_go = 0;
    int n_call = 0;
    bdcu_top bdcu_top_i (
        .clk_in(clk_in), .sys_rst_in(sys_rst_in), .dsclk_in(dsclk), .dsi_in(dsi),
        .dso_out(dso), .link_ready_out(rdy), .source_space_code_in(3'h5),
        .destination_space_code_in(3'h2), .reg_req_out(reg_req),
        .reg_req_data_out(reg_d), .reg_rdata_in(rdata), .reg_ack_in(reg_ack),
        .mem_req_out(mem_req), .mem_req_data_out(mem_d), .mem_rdata_in(rdata),
        .mem_done_in(mem_done), .mem_err_in(mem_err), .resume_out(go_p),
        .call_out(call_p), .periph_rst_out(prst)
    );
    bdcu_host bdcu_host_i (.dsclk_out(dsclk), .dsi_out(dsi), .dso_in(dso));
    always #10 clk_in = ~clk_in;
    // Bus side answers at once unless mem_hold holds memory off; request latched while it stands
    always @(negedge clk_in) begin
        reg_ack <= reg_req && !reg_ack;
        mem_done <= mem_req && !mem_done && !mem_hold;
        if (reg_req) reg_seen <= reg_d;
        if (mem_req) mem_seen <= mem_d;
    end
    // Counted on the falling edge, where the outputs have settled
    always @(negedge clk_in) begin
        n_rst += prst;
        n_go += go_p;
        n_call += call_p;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic ck(input logic [71:0] got, input logic [71:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic wc(input logic [15:0] d, input logic [16:0] e);
        bdcu_host_i.xfer({1'h0, d}, r);
        ck(r, e);
    endtask
    task automatic t_reg();
        rdata = 32'h13572468;
        wc(16'h200B, MSG_COMPLETE);
        wc(16'h89AB, MSG_NOT_READY);
        bdcu_host_i.xfer(17'h0CDEF, r);
        ck(reg_seen, {2'h2, 4'hB, 32'h89ABCDEF});
        wc(16'h2103, MSG_COMPLETE);
        ck(reg_seen[37:32], 6'h03);
        wc(16'h0000, 17'h01357);
        wc(16'h0000, 17'h02468);
        wc(16'h240E, MSG_COMPLETE);
        wc(16'h0000, MSG_NOT_READY);
        bdcu_host_i.xfer(17'h00003, r);
        ck(reg_seen, {2'h3, 4'hE, 32'h00000003});
        $display("register test done");
    endtask
    task automatic t_mem();
        rdata = 32'hA5A50F0F;
        wc(16'h1980, MSG_COMPLETE);
        wc(16'h0012, MSG_NOT_READY);
        wc(16'h3456, MSG_NOT_READY);
        ck(mem_seen[69:32], {4'h5, SZ_LONG, 32'h00123456});
        wc(16'h0000, 17'h0A5A5);
        mem_err = 1'h1;
        wc(16'h1D40, 17'h00F0F);
        ck(mem_seen[69:32], {4'h5, SZ_WORD, 32'h0012345A});
        wc(16'h0000, MSG_BERR);
        mem_err = 1'h0;
        $display("memory test done");
    endtask
    task automatic t_wr();
        wc(16'h1840, MSG_COMPLETE);
        wc(16'h0000, MSG_NOT_READY);
        wc(16'h0080, MSG_NOT_READY);
        wc(16'hBEEF, MSG_NOT_READY);
        ck({mem_seen[69:32], mem_seen[15:0]}, {4'hA, SZ_WORD, 32'h80, 16'hBEEF});
        wc(16'h1C40, MSG_COMPLETE);
        wc(16'h1234, MSG_NOT_READY);
        ck({mem_seen[69:32], mem_seen[15:0]}, {4'hA, SZ_WORD, 32'h82, 16'h1234});
        wc(16'h0000, MSG_COMPLETE);
        $display("write test done");
    endtask
    // Memory held off so a transfer lands inside the access
    task automatic t_busy();
        rdata = 32'h1234C35A;
        mem_hold <= 1'h1;
        wc(16'h1900, MSG_COMPLETE);
        wc(16'h0000, MSG_NOT_READY);
        wc(16'h0040, MSG_NOT_READY);
        wc(16'h0000, MSG_NOT_READY);
        ck(rdy, 1'h1);
        mem_hold <= 1'h0;
        repeat (8) @(negedge clk_in);
        ck(mem_seen[69:32], {4'h5, SZ_BYTE, 32'h00000040});
        wc(16'h0000, 17'h0005A);
        $display("busy test done");
    endtask
    task automatic t_ill();
        logic [15:0] bad [4] = '{16'h1BC0, 16'h1FC0, 16'h1000, 16'hFC00};
        foreach (bad[i]) begin
            wc(bad[i], (i == 0) ? MSG_COMPLETE : MSG_ILLEGAL);
            wc(bad[i], MSG_ILLEGAL);
        end
        wc(16'h0000, MSG_ILLEGAL);
        $display("illegal test done");
    endtask
    task automatic t_ctl();
        n_rst = 0;
        wc(16'h0400, MSG_COMPLETE);
        repeat (600) @(negedge clk_in);
        ck(n_rst, 32'h200);
        wc(16'h0C00, MSG_COMPLETE);
        wc(16'h0800, MSG_COMPLETE);
        wc(16'h0000, MSG_COMPLETE);
        ck({n_go, n_call}, {32'h1, 32'h1});
        $display("control test done");
    endtask
    task automatic final_report();
        $display("mismatches %0d, compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge clk_in);
        @(negedge clk_in);
        sys_rst_in = 1'h0;
        repeat (4) @(negedge clk_in);
        t_reg();
        t_mem();
        t_wr();
        t_busy();
        t_ill();
        t_ctl();
        final_report();
    end
    // About 134 us of traffic expected
    initial begin
        #300000;
        n_mismatch++;
        final_report();
    end
endmodule
